// file: logic/orps_pkg.sv
// Package: constants and types for the display reset and state block
package orps_pkg;
  // Register byte offsets
  localparam logic [11:0] ORPS_CMD_OFF    = 12'h000;
  localparam logic [11:0] ORPS_STATE_OFF  = 12'h004;
  localparam logic [11:0] ORPS_CONTR_OFF  = 12'h008;
  localparam logic [11:0] ORPS_ADDR_OFF   = 12'h00C;
  localparam logic [11:0] ORPS_SHIFT_OFF  = 12'h010;
  localparam logic [11:0] ORPS_SERIAL_OFF = 12'h014;
  // Command codes
  localparam logic [7:0] ORPS_CMD_DISP_OFF  = 8'hAE;
  localparam logic [7:0] ORPS_CMD_DISP_ON   = 8'hAF;
  localparam logic [7:0] ORPS_CMD_NORMAL    = 8'hA4;
  localparam logic [7:0] ORPS_CMD_ALL_ON    = 8'hA5;
  localparam logic [7:0] ORPS_CMD_SEG_NORM  = 8'hA0;
  localparam logic [7:0] ORPS_CMD_SEG_REV   = 8'hA1;
  localparam logic [7:0] ORPS_CMD_COM_NORM  = 8'hC0;
  localparam logic [7:0] ORPS_CMD_COM_REV   = 8'hC8;
  // Reset values and counter limits
  localparam logic [7:0] ORPS_CONTRAST_RST  = 8'h7F;
  localparam logic [5:0] ORPS_MUX_RST       = 6'h3F;
  localparam logic [5:0] ORPS_START_RST     = 6'h00;
  localparam logic [6:0] ORPS_COL_RST       = 7'h00;
  localparam logic [6:0] ORPS_COL_MAX       = 7'h7F;
  localparam logic [7:0] ORPS_SHIFT_RST     = 8'h00;
  localparam logic [2:0] ORPS_BITCNT_RST    = 3'h0;
  localparam logic [2:0] ORPS_BITCNT_LAST   = 3'h7;
  // Display state fields in the state register
  localparam int ORPS_ST_ON_BIT   = 0;
  localparam int ORPS_ST_ALL_BIT  = 1;
  localparam int ORPS_ST_SEG_BIT  = 2;
  localparam int ORPS_ST_COM_BIT  = 3;
  localparam int ORPS_ST_MUX_LSB  = 8;
  localparam int ORPS_ST_STL_LSB  = 16;

  typedef struct packed {
    logic       disp_on;
    logic       all_on;
    logic       seg_rev;
    logic       com_rev;
    logic [5:0] mux;
    logic [5:0] start_line;
    logic [7:0] contrast;
    logic [6:0] column;
  } orps_state_t;

  localparam orps_state_t ORPS_STATE_RST = '{
    disp_on: 1'b0, all_on: 1'b0, seg_rev: 1'b0, com_rev: 1'b0,
    mux: ORPS_MUX_RST, start_line: ORPS_START_RST,
    contrast: ORPS_CONTRAST_RST, column: ORPS_COL_RST};
endpackage : orps_pkg

// file: logic/orps_shift.sv
// Serial input shift register, cleared by reset
`timescale 1ns/1ps
`default_nettype none
module orps_shift
  import orps_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sclk_rise,
  input  wire logic       sdin,
  output logic [7:0]      byte_data,
  output logic            byte_valid
);
  logic [7:0] shift_q, shift_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] byte_q, byte_d;
  logic       vld_q, vld_d;

  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    byte_d  = byte_q;
    vld_d   = 1'b0;
    if (sclk_rise) begin
      shift_d = {shift_q[6:0], sdin};
      cnt_d   = cnt_q + 3'h1;
      if (cnt_q == ORPS_BITCNT_LAST) begin
        byte_d = {shift_q[6:0], sdin};
        vld_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= ORPS_SHIFT_RST;
      cnt_q   <= ORPS_BITCNT_RST;
      byte_q  <= ORPS_SHIFT_RST;
      vld_q   <= 1'b0;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      byte_q  <= byte_d;
      vld_q   <= vld_d;
    end
  end

  assign byte_data  = byte_q;
  assign byte_valid = vld_q;
endmodule : orps_shift
`default_nettype wire

// file: logic/orps_top.sv
// Display driver state block: reset defaults, commands, APB registers
`timescale 1ns/1ps
`default_nettype none
module orps_top
  import orps_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clk,
  input  wire logic        serial_din,
  output logic             panel_on,
  output logic             all_pixels_on,
  output logic             first_segment_driver_rev,
  output logic             first_common_driver_rev,
  output logic [5:0]       mux_ratio,
  output logic [5:0]       start_line,
  output logic [7:0]       contrast,
  output logic [6:0]       column_addr
);
  orps_state_t st_q, st_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic [1:0]  sclk_sync_q, sclk_sync_d;
  logic        sclk_prev_q, sclk_prev_d;
  logic [1:0]  sdin_sync_q, sdin_sync_d;
  logic        sclk_rise;
  logic [7:0]  ser_byte;
  logic        ser_valid;
  logic        apb_acc;
  logic        apb_wr;
  logic        cmd_wr;
  logic        data_wr;
  logic        mapped;
  logic [7:0]  cmd_byte;

  // Pin synchronisers and edge detect on second stage only
  always_comb begin
    sclk_sync_d = {sclk_sync_q[0], serial_clk};
    sdin_sync_d = {sdin_sync_q[0], serial_din};
    sclk_prev_d = sclk_sync_q[1];
  end
  assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_sync_q <= 2'h0;
      sdin_sync_q <= 2'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_sync_q <= sclk_sync_d;
      sdin_sync_q <= sdin_sync_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  orps_shift u_shift (
    .pclk       (pclk),
    .presetn    (presetn),
    .sclk_rise  (sclk_rise),
    .sdin       (sdin_sync_q[1]),
    .byte_data  (ser_byte),
    .byte_valid (ser_valid)
  );

  assign apb_acc = psel & penable;
  assign apb_wr  = apb_acc & pwrite;
  always_comb begin
    unique case (paddr)
      ORPS_CMD_OFF, ORPS_STATE_OFF, ORPS_CONTR_OFF,
      ORPS_ADDR_OFF, ORPS_SHIFT_OFF, ORPS_SERIAL_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign cmd_wr  = apb_wr & (paddr == ORPS_CMD_OFF) & pstrb[0];
  assign data_wr = apb_wr & (paddr == ORPS_SERIAL_OFF) & pstrb[0];
  // APB command wins over a serial byte in the same cycle
  assign cmd_byte = cmd_wr ? pwdata[7:0] : ser_byte;

  // Display state next values
  always_comb begin
    st_d = st_q;
    if (cmd_wr || ser_valid) begin
      unique case (cmd_byte)
        ORPS_CMD_DISP_OFF: st_d.disp_on = 1'b0;
        ORPS_CMD_DISP_ON:  st_d.disp_on = 1'b1;
        ORPS_CMD_NORMAL:   st_d.all_on  = 1'b0;
        ORPS_CMD_ALL_ON:   st_d.all_on  = 1'b1;
        ORPS_CMD_SEG_NORM: st_d.seg_rev = 1'b0;
        ORPS_CMD_SEG_REV:  st_d.seg_rev = 1'b1;
        ORPS_CMD_COM_NORM: st_d.com_rev = 1'b0;
        ORPS_CMD_COM_REV:  st_d.com_rev = 1'b1;
        default: begin
          if (cmd_byte[7:6] == 2'h1) begin
            st_d.start_line = cmd_byte[5:0];
          end
        end
      endcase
    end
    if (apb_wr && paddr == ORPS_CONTR_OFF && pstrb[0]) begin
      st_d.contrast = pwdata[7:0];
    end
    if (apb_wr && paddr == ORPS_ADDR_OFF) begin
      if (pstrb[0]) begin
        st_d.column = pwdata[6:0];
      end
      if (pstrb[1]) begin
        st_d.mux = pwdata[13:8];
      end
    end
    if (data_wr) begin
      st_d.column = (st_q.column == ORPS_COL_MAX) ? ORPS_COL_RST
                                                  : st_q.column + 7'h01;
    end
  end

  // Defaults persist after release until commands or APB register writes change them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ORPS_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // APB read data and error
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (psel && !penable) begin
      err_d = ~mapped;
      unique case (paddr)
        ORPS_STATE_OFF: begin
          rdata_d[ORPS_ST_ON_BIT]  = st_q.disp_on;
          rdata_d[ORPS_ST_ALL_BIT] = st_q.all_on;
          rdata_d[ORPS_ST_SEG_BIT] = st_q.seg_rev;
          rdata_d[ORPS_ST_COM_BIT] = st_q.com_rev;
          rdata_d[ORPS_ST_MUX_LSB +: 6] = st_q.mux;
          rdata_d[ORPS_ST_STL_LSB +: 6] = st_q.start_line;
        end
        ORPS_CONTR_OFF: rdata_d[7:0] = st_q.contrast;
        ORPS_ADDR_OFF: begin
          rdata_d[6:0]  = st_q.column;
          rdata_d[13:8] = st_q.mux;
        end
        ORPS_SHIFT_OFF: rdata_d[7:0] = ser_byte;
        default: rdata_d = 32'h0000_0000;
      endcase
    end else if (apb_acc) begin
      rdata_d = rdata_q;
      err_d   = err_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = err_q & apb_acc;

  assign panel_on                 = st_q.disp_on;
  assign all_pixels_on            = st_q.all_on;
  assign first_segment_driver_rev = st_q.seg_rev;
  assign first_common_driver_rev  = st_q.com_rev;
  assign mux_ratio                = st_q.mux;
  assign start_line               = st_q.start_line;
  assign contrast                 = st_q.contrast;
  assign column_addr              = st_q.column;
endmodule : orps_top
`default_nettype wire

// file: testbench/orps_props.sv
// Checker for reset defaults and register writes
`timescale 1ns/1ps
`default_nettype none
module orps_props
  import orps_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        serial_clk,
  input wire logic        panel_on,
  input wire logic        all_pixels_on,
  input wire logic        first_segment_driver_rev,
  input wire logic        first_common_driver_rev,
  input wire logic [5:0]  mux_ratio,
  input wire logic [5:0]  start_line,
  input wire logic [7:0]  contrast,
  input wire logic [6:0]  column_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rel_s;
    $rose(presetn);
  endsequence
  sequence quiet_s;
    (!psel && !serial_clk)[*4];
  endsequence
  off_at_reset_a: assert property (rel_s |-> !panel_on && mux_ratio == 6'h3F)
    else $error("display not off after reset");
  seg_at_reset_a: assert property (rel_s |-> !first_segment_driver_rev)
    else $error("segment map not normal after reset");
  start_at_reset_a: assert property (rel_s |-> start_line == 6'h00)
    else $error("start line not zero after reset");
  col_at_reset_a: assert property (rel_s |-> column_addr == 7'h00)
    else $error("column not zero after reset");
  com_at_reset_a: assert property (rel_s |-> !first_common_driver_rev)
    else $error("common scan not normal after reset");
  contr_at_reset_a: assert property (rel_s |-> contrast == 8'h7F)
    else $error("contrast not 7F after reset");
  mode_at_reset_a: assert property (rel_s |-> !all_pixels_on)
    else $error("display mode not normal after reset");
  defaults_hold_a: assert property (rel_s ##0 quiet_s |-> contrast == 8'h7F && !panel_on)
    else $error("defaults lost without command");
  contr_write_a: assert property (psel && penable && pwrite && paddr == ORPS_CONTR_OFF
    && pstrb[0] |=> contrast == $past(pwdata[7:0]))
    else $error("contrast write not applied");
  unmapped_err_a: assert property (psel && penable && paddr == 12'h018 |-> pslverr
    && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : orps_props
bind orps_top orps_props u_props (.*);
`default_nettype wire

// file: testbench/orps_host_model.sv
// Host model that shifts command bytes into the serial pins
`timescale 1ns/1ps
`default_nettype none
module orps_host_model (
  input  wire logic pclk,
  output logic      serial_clk,
  output logic      serial_din
);
  initial begin
    serial_clk = 1'b0;
    serial_din = 1'b0;
  end
  // Clock stands low between frames; data flips once released
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk) serial_din <= b[7 - i];
      repeat (3) @(posedge pclk);
      serial_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      serial_clk <= 1'b0;
    end
    @(posedge pclk) serial_din <= ~serial_din;
  endtask : send_bits
endmodule : orps_host_model
`default_nettype wire

// file: testbench/orps_top_bench.sv
// Bench for reset defaults, commands and serial bytes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module orps_top_bench
  import orps_pkg::*;
;
  localparam int SETTLE = 40; // Panel supply settle, scaled down
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        serial_clk, serial_din, panel_on, all_on, seg_rev, com_rev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [5:0]  mux_ratio, start_line;
  logic [7:0]  contrast;
  logic [6:0]  column_addr;
  logic [7:0]  on_cmds [4] = '{8'hAF, 8'hA5, 8'hA1, 8'hC8};
  logic [7:0]  off_cmds [4] = '{8'hAE, 8'hA4, 8'hA0, 8'hC0};
  int          bad_count = 0;
  int          num_checks = 0;
  orps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk), .serial_din(serial_din),
    .panel_on(panel_on), .all_pixels_on(all_on), .first_segment_driver_rev(seg_rev),
    .first_common_driver_rev(com_rev), .mux_ratio(mux_ratio), .start_line(start_line),
    .contrast(contrast), .column_addr(column_addr));
  orps_host_model host (.pclk(pclk), .serial_clk(serial_clk), .serial_din(serial_din));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic do_reset;
    @(posedge pclk) presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset
  task automatic chk_defaults;
    `CHK({panel_on, mux_ratio}, 7'h3F)
    `CHK({seg_rev, com_rev}, 2'b00)
    `CHK(start_line, 6'h00)
    `CHK(column_addr, 7'h00)
    `CHK(contrast, 8'h7F)
    `CHK(all_on, 1'b0)
    apb(1'b0, ORPS_STATE_OFF, 32'h0);
    `CHK(rd, 32'h00003F00)
    apb(1'b0, ORPS_SHIFT_OFF, 32'h0);
    `CHK(rd, 32'h0)
    $display("test defaults done");
  endtask : chk_defaults
  initial begin
    #100us;
    bad_count++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    do_reset();
    chk_defaults();
    apb(1'b1, ORPS_CMD_OFF, 32'h45);
    apb(1'b1, ORPS_CONTR_OFF, 32'h10);
    for (int i = 0; i < 4; i++) apb(1'b1, ORPS_CMD_OFF, {24'h0, on_cmds[i]});
    apb(1'b0, ORPS_STATE_OFF, 32'h0);
    `CHK(rd, 32'h00053F0F)
    for (int i = 0; i < 4; i++) apb(1'b1, ORPS_CMD_OFF, {24'h0, off_cmds[i]});
    apb(1'b0, ORPS_STATE_OFF, 32'h0);
    `CHK(rd, 32'h00053F00)
    apb(1'b0, ORPS_CONTR_OFF, 32'h0);
    `CHK(rd, 32'h10)
    repeat (2) apb(1'b1, ORPS_SERIAL_OFF, 32'h0);
    @(negedge pclk);
    `CHK(column_addr, 7'h02)
    apb(1'b1, ORPS_ADDR_OFF, 32'h1F7F);
    apb(1'b1, ORPS_SERIAL_OFF, 32'h0);
    @(negedge pclk);
    `CHK({mux_ratio, column_addr}, 13'h0F80)
    apb(1'b0, 12'h018, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("test commands done");
    host.send_bits(8'hFF, 8);
    apb(1'b0, ORPS_SHIFT_OFF, 32'h0);
    `CHK(rd, 32'h000000FF)
    host.send_bits(8'hFF, 3);
    do_reset();
    chk_defaults();
    host.send_bits(ORPS_CMD_DISP_OFF, 8);
    repeat (SETTLE) @(posedge pclk);
    host.send_bits(ORPS_CMD_DISP_ON, 8);
    repeat (4) @(posedge pclk);
    `CHK(panel_on, 1'b1)
    host.send_bits(ORPS_CMD_DISP_OFF, 8);
    repeat (4) @(posedge pclk);
    `CHK(panel_on, 1'b0)
    $display("test serial done");
    conclude();
  end
endmodule : orps_top_bench
`default_nettype wire
